// ---- src/swdpf_params.svh ----
/*
  Timing constants for the supervisor watchdog block.
  Assumes the clock runs at 10 MHz and is included by bare name.
*/
`ifndef SWDPF_PARAMS_SVH
`define SWDPF_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------
`define SWDPF_CLK_HZ        10000000
`define SWDPF_TIMEOUT_MS    1600
`define SWDPF_TIMEOUT_MIN_MS 1000
`define SWDPF_RESET_MS      140
`define SWDPF_CYC_PER_MS    (`SWDPF_CLK_HZ / 1000)
`define SWDPF_TIMEOUT_CYC   (`SWDPF_TIMEOUT_MS * `SWDPF_CYC_PER_MS)
`define SWDPF_RESET_CYC     (`SWDPF_RESET_MS * `SWDPF_CYC_PER_MS)
`define SWDPF_CNT_W         32

`endif

// ---- src/swdpf_pkg.sv ----
/*
  Types for the supervisor watchdog block.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package swdpf_pkg;
  typedef enum logic [0:0] {
    swdpf_timing,
    swdpf_resetting
  } swdpf_state_e;
endpackage
`default_nettype wire

// ---- src/swdpf_watchdog.sv ----
/*
  Watchdog supervisor with timeout flag, power-fail flag and memory
  chip-select gating. Assumes all inputs synchronous to clock, a
  kick-floating detector outside, and comparator results given as levels.
*/
`include "swdpf_params.svh"
`default_nettype none
module swdpf_watchdog #(
  parameter logic [`SWDPF_CNT_W-1:0] TIMEOUT_CYC = `SWDPF_CNT_W'(`SWDPF_TIMEOUT_CYC),
  parameter logic [`SWDPF_CNT_W-1:0] RESET_CYC   = `SWDPF_CNT_W'(`SWDPF_RESET_CYC)
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Host side
  input  wire logic kick_in,
  input  wire logic kick_floating,
  input  wire logic mem_cs_in_n,
  // Supply monitors
  input  wire logic supply_valid,
  input  wire logic battery_backup,
  input  wire logic supply_sense_in,
  // Outputs
  output logic      reset_out,
  output logic      reset_out_n,
  output logic      timeout_flag_n,
  output logic      supply_fail_n,
  output logic      mem_cs_out_n
);

  // ----------------------------------------------------------------
  // Watchdog state
  // ----------------------------------------------------------------
  swdpf_pkg::swdpf_state_e          state;
  swdpf_pkg::swdpf_state_e          next_state;
  logic [`SWDPF_CNT_W-1:0]          count;
  logic [`SWDPF_CNT_W-1:0]          next_count;
  logic                             kick_prev;
  logic                             next_kick_prev;
  logic                             next_reset_out;
  logic                             next_timeout_flag_n;
  logic                             next_supply_fail_n;
  logic                             next_mem_cs_out_n;
  logic                             kick_edge;
  logic                             enabled;

  always_comb
  begin
    // Backup also means supply below threshold
    enabled   = supply_valid && !battery_backup && !kick_floating;
    kick_edge = enabled && (kick_in != kick_prev);
    next_kick_prev      = kick_in;
    next_state          = state;
    next_count          = count;
    next_reset_out      = reset_out;
    next_timeout_flag_n = timeout_flag_n;
    if (!enabled)
    begin
      // Drop any pending pulse; supply resets belong to other logic
      next_state          = swdpf_pkg::swdpf_timing;
      next_count          = '0;
      next_reset_out      = 1'b0;
      next_timeout_flag_n = 1'b1;
    end
    else
    begin
      unique case (state)
        swdpf_pkg::swdpf_timing:
        begin
          if (kick_edge)
          begin
            next_count          = '0;
            next_timeout_flag_n = 1'b1;
          end
          else if (count >= TIMEOUT_CYC - 1'b1)
          begin
            next_state          = swdpf_pkg::swdpf_resetting;
            next_count          = '0;
            next_reset_out      = 1'b1;
            next_timeout_flag_n = 1'b0;
          end
          else
          begin
            next_count = count + 1'b1;
          end
        end
        swdpf_pkg::swdpf_resetting:
        begin
          // Kick edges clear the flag but never shorten the pulse
          if (kick_edge)
          begin
            next_timeout_flag_n = 1'b1;
          end
          if (count >= RESET_CYC - 1'b1)
          begin
            next_state     = swdpf_pkg::swdpf_timing;
            next_count     = '0;
            next_reset_out = 1'b0;
          end
          else
          begin
            next_count = count + 1'b1;
          end
        end
      endcase
    end
    next_supply_fail_n = supply_sense_in;
    next_mem_cs_out_n  = battery_backup || !supply_valid || mem_cs_in_n;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state          <= swdpf_pkg::swdpf_timing;
      count          <= '0;
      kick_prev      <= 1'b0;
      reset_out      <= 1'b0;
      reset_out_n    <= 1'b1;
      timeout_flag_n <= 1'b1;
      supply_fail_n  <= 1'b1;
      mem_cs_out_n   <= 1'b1;
    end
    else
    begin
      state          <= next_state;
      count          <= next_count;
      kick_prev      <= next_kick_prev;
      reset_out      <= next_reset_out;
      reset_out_n    <= !next_reset_out;
      timeout_flag_n <= next_timeout_flag_n;
      supply_fail_n  <= next_supply_fail_n;
      mem_cs_out_n   <= next_mem_cs_out_n;
    end
  end

endmodule // swdpf_watchdog
`default_nettype wire

// ---- verification/swdpf_host.sv ----
/* Host model that toggles the kick line every 8 cycles.
   Assumes the bench gates it through go. */
`default_nettype none
module swdpf_host (
  input  wire logic clock,
  input  wire logic go,
  output var logic  kick_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] n = 3'h0;
  initial kick_in = 1'h0;
  // Well inside the timeout, so no expiry while go
  always @(posedge clock)
    if (go)
    begin
      n <= n + 3'h1;
      if (n == 3'h7) kick_in <= !kick_in;
    end
endmodule // swdpf_host
`default_nettype wire

// ---- verification/swdpf_watchdog_chk.sv ----
/* Port checker for swdpf_watchdog.
   Assumes one clock and the sync reset rst. */
`default_nettype none
module swdpf_chk #(
  parameter logic [31:0] TIMEOUT_CYC = 32'h14,
  parameter logic [31:0] RESET_CYC   = 32'h5
) (
  input wire logic clock, rst, kick_in, kick_floating, mem_cs_in_n, supply_valid,
  input wire logic battery_backup, supply_sense_in, reset_out, reset_out_n,
  input wire logic timeout_flag_n, supply_fail_n, mem_cs_out_n
);
  logic        en, kprev;
  logic [31:0] idle, hi;
  assign en = supply_valid & !battery_backup & !kick_floating;
  always_ff @(posedge clock)
  begin
    kprev <= rst ? 1'h0 : kick_in;
    hi <= (rst || !reset_out) ? 32'h0 : hi + 32'h1;
    idle <= (rst || !en || reset_out || kick_in != kprev) ? 32'h0 : idle + 32'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_quiet; en && !reset_out && kick_in == kprev; endsequence
  AST_EXPIRE: assert property (s_quiet ##0 idle == TIMEOUT_CYC - 1 |=> reset_out)
    else $error("no reset at expiry");
  AST_EARLY: assert property (!reset_out && idle < TIMEOUT_CYC - 1 |=> !reset_out)
    else $error("early reset");
  AST_HOLD: assert property (reset_out && en && hi < RESET_CYC - 1 |=> reset_out)
    else $error("short pulse");
  AST_END: assert property (reset_out && hi == RESET_CYC - 1 |=> !reset_out)
    else $error("long pulse");
  AST_POL: assert property (reset_out_n != reset_out)
    else $error("polarity");
  AST_FLAG: assert property ($rose(reset_out) |-> !timeout_flag_n)
    else $error("flag not low");
  AST_STAY: assert property (!timeout_flag_n && en && kick_in == kprev |=> !timeout_flag_n)
    else $error("flag left low");
  AST_OFF: assert property (!en |=> !reset_out && timeout_flag_n)
    else $error("not disabled");
  AST_PF: assert property (1'h1 |=> supply_fail_n == $past(supply_sense_in))
    else $error("power flag");
  AST_CS: assert property (battery_backup || !supply_valid |=> mem_cs_out_n)
    else $error("chip select");
endmodule // swdpf_chk
bind swdpf_watchdog swdpf_chk #(.TIMEOUT_CYC(TIMEOUT_CYC), .RESET_CYC(RESET_CYC)) u_chk (.*);
`default_nettype wire

// ---- verification/swdpf_watchdog_test.sv ----
/* Self-checking bench for swdpf_watchdog with a host model.
   Assumes the checker binds itself to the design. */
`default_nettype none
module swdpf_watchdog_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'h0, rst = 1'h1, go = 1'h0, kick_floating = 1'h0, mem_cs_in_n = 1'h1;
  logic supply_valid = 1'h1, battery_backup = 1'h0, supply_sense_in = 1'h1;
  wire logic kick_in, reset_out, reset_out_n, timeout_flag_n, supply_fail_n, mem_cs_out_n;
  int fail_count = 0, cmp_count = 0, cyc = 0, t0;
  swdpf_host host (.clock, .go, .kick_in);
  // Short counts: timeout 20, pulse 5
  swdpf_watchdog #(.TIMEOUT_CYC(32'h14), .RESET_CYC(32'h5)) dut (.*);
  initial forever #50 clock = !clock;
  always @(posedge clock) if (++cyc == 2000) begin fail_count++; finish_test(); end
  task step(input int n); repeat (n) @(posedge clock); #1; endtask
  task chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin fail_count++; $display("unexpected %0t value %0h", $time, s); end
  endtask
  task finish_test;
    $display("mismatches %0d of %0d checks", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task t_kick;
    go = 1'h1;
    step(200);
    chk({reset_out, timeout_flag_n}, 2'h1);
  endtask
  task t_expire;
    go = 1'h0;
    while (!reset_out) step(1);
    t0 = cyc;
    chk({timeout_flag_n, reset_out_n}, 2'h0);
    while (reset_out) step(1);
    chk(cyc - t0, 5);
    while (!reset_out) step(1);
    chk(cyc - t0, 25);
    go = 1'h1;
    step(12);
    chk(timeout_flag_n, 1'h1);
    go = 1'h0;
  endtask
  task t_supply;
    mem_cs_in_n = 1'h0;
    supply_sense_in = 1'h0;
    step(2);
    chk({mem_cs_out_n, supply_fail_n}, 2'h0);
    supply_valid = 1'h0;
    step(30);
    chk({reset_out, timeout_flag_n, mem_cs_out_n}, 3'h3);
    supply_valid = 1'h1;
    battery_backup = 1'h1;
    step(30);
    chk({reset_out, mem_cs_out_n}, 2'h1);
    battery_backup = 1'h0;
    kick_floating = 1'h1;
    step(30);
    chk(reset_out, 1'h0);
  endtask
  initial
  begin
    step(12);
    rst = 1'h0;
    t_kick();
    t_expire();
    t_supply();
    finish_test();
  end
endmodule // swdpf_watchdog_test
`default_nettype wire
